// ===== common/rcd_pkg.sv
package rcd_pkg;
  // Clock rate of the processing clock
  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_FREQ_HZ = 40000000;

  // Sample code: three bits, code k stands for level 2k-7
  localparam int CODE_W = 3;
  localparam int LVL_W = 4;
  localparam int FIL_W = 11;
  localparam int HALF_W = 5;

  // Odd-indexed history length and in-phase alignment delay
  localparam int Q_TAPS = 10;
  localparam int Q_PAIRS = 5;
  localparam int I_DELAY = 5;

  // Shared coefficients of the pre-added pairs (1/19, 3/17, 5/15, 7/13, 9/11)
  localparam logic signed [FIL_W-1:0] COEF_P0 = 11'sh002;
  localparam logic signed [FIL_W-1:0] COEF_P1 = -11'sh003;
  localparam logic signed [FIL_W-1:0] COEF_P2 = 11'sh005;
  localparam logic signed [FIL_W-1:0] COEF_P3 = -11'sh009;
  localparam logic signed [FIL_W-1:0] COEF_P4 = 11'sh01E;
  // Centre tap, folded into the in-phase bypass
  localparam logic signed [FIL_W-1:0] COEF_CENTRE = 11'sh02F;

  // Filter output span and requantiser thresholds
  localparam logic signed [FIL_W-1:0] FIL_MAX = 11'sh157;
  localparam logic signed [FIL_W-1:0] FIL_MIN = -11'sh157;
  localparam logic signed [FIL_W-1:0] THR_2 = 11'sh11B;
  localparam logic signed [FIL_W-1:0] THR_1 = 11'sh0BD;
  localparam logic signed [FIL_W-1:0] THR_0 = 11'sh05F;
  localparam logic signed [FIL_W-1:0] THR_N0 = -11'sh05E;
  localparam logic signed [FIL_W-1:0] THR_N1 = -11'sh0BC;
  localparam logic signed [FIL_W-1:0] THR_N2 = -11'sh11A;

  // Output codes
  localparam logic [CODE_W-1:0] CODE_P7 = 3'h7;
  localparam logic [CODE_W-1:0] CODE_P5 = 3'h6;
  localparam logic [CODE_W-1:0] CODE_P3 = 3'h5;
  localparam logic [CODE_W-1:0] CODE_P1 = 3'h4;
  localparam logic [CODE_W-1:0] CODE_M1 = 3'h3;
  localparam logic [CODE_W-1:0] CODE_M3 = 3'h2;
  localparam logic [CODE_W-1:0] CODE_M5 = 3'h1;
  localparam logic [CODE_W-1:0] CODE_M7 = 3'h0;

  // Reset values
  localparam logic [CODE_W-1:0] CODE_RST = 3'h0;
  localparam logic signed [LVL_W-1:0] LVL_RST = 4'sh0;
  localparam logic [1:0] CNT_RST = 2'h0;
  localparam int BUF_DEPTH = 2;
endpackage

// ===== rtl/rcd_requant.sv
`timescale 1ns/10ps
module rcd_requant (
  input wire logic signed [rcd_pkg::FIL_W-1:0] value_i,
  output logic [rcd_pkg::CODE_W-1:0] code_o
);
  // Constant threshold ladder, evenly spread over the filter span
  assign code_o = (value_i >= rcd_pkg::THR_2) ? rcd_pkg::CODE_P7 :
                  (value_i >= rcd_pkg::THR_1) ? rcd_pkg::CODE_P5 :
                  (value_i >= rcd_pkg::THR_0) ? rcd_pkg::CODE_P3 :
                  (value_i >= 11'sh000) ? rcd_pkg::CODE_P1 :
                  (value_i >= rcd_pkg::THR_N0) ? rcd_pkg::CODE_M1 :
                  (value_i >= rcd_pkg::THR_N1) ? rcd_pkg::CODE_M3 :
                  (value_i >= rcd_pkg::THR_N2) ? rcd_pkg::CODE_M5 : rcd_pkg::CODE_M7;
endmodule

// ===== rtl/rcd_buf2.sv
`timescale 1ns/10ps
module rcd_buf2 #(
  parameter int W = 6
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic [W-1:0] head_ff;
  logic [W-1:0] tail_ff;
  logic [W-1:0] nxt_head;
  logic [W-1:0] nxt_tail;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  // Honest full and empty from the occupancy count
  assign in_ready_o = (cnt_ff != 2'h2);
  assign out_valid_o = (cnt_ff != 2'h0);
  assign out_data_o = head_ff;

  // Head always holds the oldest word so the output comes from a flop
  assign nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
  assign nxt_head = (push && (cnt_ff == 2'h0 || (pop && cnt_ff == 2'h1))) ? in_data_i :
                    (pop ? tail_ff : head_ff);
  assign nxt_tail = (push && ((cnt_ff == 2'h1 && !pop) || cnt_ff == 2'h2)) ? in_data_i : tail_ff;

  // Storage and count
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_ff <= rcd_pkg::CNT_RST;
      head_ff <= '0;
      tail_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      head_ff <= nxt_head;
      tail_ff <= nxt_tail;
    end
  end
endmodule

// ===== rtl/rcd_downconv.sv
`timescale 1ns/10ps
module rcd_downconv (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic real_to_complex_mode_i,
  input wire logic [rcd_pkg::CODE_W-1:0] antenna_sample_input_i,
  output logic iq_valid_o,
  input wire logic iq_ready_i,
  output logic [rcd_pkg::CODE_W-1:0] inphase_o,
  output logic [rcd_pkg::CODE_W-1:0] quad_o,
  output logic sample_drop_o
);
  // Capture and retime registers, three flops per path
  logic [rcd_pkg::CODE_W-1:0] rise_cap_ff;
  logic [rcd_pkg::CODE_W-1:0] fall_cap_ff;
  logic [rcd_pkg::CODE_W-1:0] rise_s1_ff;
  logic [rcd_pkg::CODE_W-1:0] fall_s1_ff;
  logic [rcd_pkg::CODE_W-1:0] rise_s2_ff;
  logic [rcd_pkg::CODE_W-1:0] fall_s2_ff;
  // Mixer state and filter histories
  logic phase_ff;
  logic signed [rcd_pkg::LVL_W-1:0] q_hist_ff [rcd_pkg::Q_TAPS];
  logic signed [rcd_pkg::LVL_W-1:0] i_hist_ff [rcd_pkg::I_DELAY];
  logic drop_ff;
  // Datapath wires
  logic signed [rcd_pkg::LVL_W-1:0] rise_lvl;
  logic signed [rcd_pkg::LVL_W-1:0] fall_lvl;
  logic signed [rcd_pkg::LVL_W-1:0] inphase_mixed;
  logic signed [rcd_pkg::LVL_W-1:0] quad_mixed;
  logic signed [rcd_pkg::HALF_W-1:0] pair_half [rcd_pkg::Q_PAIRS];
  logic signed [rcd_pkg::FIL_W-1:0] pair_coef [rcd_pkg::Q_PAIRS];
  logic signed [rcd_pkg::FIL_W-1:0] pair_prod [rcd_pkg::Q_PAIRS];
  logic signed [rcd_pkg::FIL_W-1:0] quad_filtered;
  logic signed [rcd_pkg::LVL_W-1:0] inphase_filtered;
  logic [rcd_pkg::CODE_W-1:0] quad_code;
  logic [rcd_pkg::CODE_W-1:0] inphase_code;
  logic buf_ready;
  logic advance;

  // Rising-edge half of each input pair
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rise_cap_ff <= rcd_pkg::CODE_RST;
    end else begin
      rise_cap_ff <= antenna_sample_input_i;
    end
  end

  // Falling-edge half, taken half a period after its partner
  always_ff @(negedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fall_cap_ff <= rcd_pkg::CODE_RST;
    end else begin
      fall_cap_ff <= antenna_sample_input_i;
    end
  end

  // Both halves moved onto rising edges; no second clock is involved
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rise_s1_ff <= rcd_pkg::CODE_RST;
      fall_s1_ff <= rcd_pkg::CODE_RST;
      rise_s2_ff <= rcd_pkg::CODE_RST;
      fall_s2_ff <= rcd_pkg::CODE_RST;
    end else begin
      rise_s1_ff <= rise_cap_ff;
      fall_s1_ff <= fall_cap_ff;
      rise_s2_ff <= rise_s1_ff;
      fall_s2_ff <= fall_s1_ff;
    end
  end

  // Pipeline moves only while the mode is on and the buffer has room
  assign advance = real_to_complex_mode_i && buf_ready;

  // Code k means level 2k-7: flip the top bit and append a one
  assign rise_lvl = {~rise_s2_ff[2], rise_s2_ff[1:0], 1'b1};
  assign fall_lvl = {~fall_s2_ff[2], fall_s2_ff[1:0], 1'b1};

  // Quarter-rate carrier: the rising sample sees 1,-1 on the cosine arm,
  // the falling one sees +1,-1 on the sine arm, so the zeros never exist
  assign inphase_mixed = phase_ff ? -rise_lvl : rise_lvl;
  assign quad_mixed = phase_ff ? -fall_lvl : fall_lvl;

  // Carrier phase toggles once per processed pair
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_ff <= 1'b0;
    end else if (advance) begin
      phase_ff <= ~phase_ff;
    end
  end

  // Odd-sample history for quadrature, short delay for in-phase; one step per advance
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int k = 0; k < rcd_pkg::Q_TAPS; k++) begin
        q_hist_ff[k] <= rcd_pkg::LVL_RST;
      end
      for (int k = 0; k < rcd_pkg::I_DELAY; k++) begin
        i_hist_ff[k] <= rcd_pkg::LVL_RST;
      end
    end else if (advance) begin
      q_hist_ff[0] <= quad_mixed;
      i_hist_ff[0] <= inphase_mixed;
      for (int k = 1; k < rcd_pkg::Q_TAPS; k++) begin
        q_hist_ff[k] <= q_hist_ff[k-1];
      end
      for (int k = 1; k < rcd_pkg::I_DELAY; k++) begin
        i_hist_ff[k] <= i_hist_ff[k-1];
      end
    end
  end

  // Shared coefficients of the five symmetric pairs
  assign pair_coef[0] = rcd_pkg::COEF_P0;
  assign pair_coef[1] = rcd_pkg::COEF_P1;
  assign pair_coef[2] = rcd_pkg::COEF_P2;
  assign pair_coef[3] = rcd_pkg::COEF_P3;
  assign pair_coef[4] = rcd_pkg::COEF_P4;

  // Pre-add each symmetric pair; two odd levels sum to an even number, so
  // halving is exact and keeps the result within the documented span
  for (genvar p = 0; p < rcd_pkg::Q_PAIRS; p++) begin : g_pair
    wire signed [rcd_pkg::HALF_W-1:0] pair_sum =
      {q_hist_ff[p][3], q_hist_ff[p]} + {q_hist_ff[rcd_pkg::Q_TAPS-1-p][3], q_hist_ff[rcd_pkg::Q_TAPS-1-p]};
    assign pair_half[p] = pair_sum >>> 1;
    assign pair_prod[p] = pair_coef[p] * {{6{pair_half[p][4]}}, pair_half[p]};
  end

  // Only the five pre-added pair products of the ten odd taps reach the adder tree
  assign quad_filtered = pair_prod[0] + pair_prod[1] + pair_prod[2] + pair_prod[3] + pair_prod[4];

  // Centre sample sits between the two middle odd samples of the window
  assign inphase_filtered = i_hist_ff[rcd_pkg::I_DELAY-1];

  // Quadrature requantiser
  rcd_requant u_quant_q (
    .value_i(quad_filtered),
    .code_o(quad_code)
  );

  // Level times the centre tap lands exactly on the band of the same level
  // under the shared ladder, so the code is the level itself; no multiplier
  assign inphase_code = {~inphase_filtered[3], inphase_filtered[2:1]};

  // Two-entry buffer holds every word it has taken through a receiver stall
  rcd_buf2 #(
    .W(2 * rcd_pkg::CODE_W)
  ) u_buf (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(advance),
    .in_ready_o(buf_ready),
    .in_data_i({inphase_code, quad_code}),
    .out_valid_o(iq_valid_o),
    .out_ready_i(iq_ready_i),
    .out_data_o({inphase_o, quad_o})
  );

  // Input pairs arriving while the buffer is full cannot be held
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drop_ff <= 1'b0;
    end else begin
      drop_ff <= real_to_complex_mode_i && !buf_ready;
    end
  end
  assign sample_drop_o = drop_ff;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_fall_retime: assert property (fall_s2_ff == $past(fall_cap_ff, 2))
    else $error("falling-edge sample not retimed in two cycles");

  a_rise_retime: assert property (rise_s2_ff == $past(rise_cap_ff, 2))
    else $error("rising-edge sample not retimed in two cycles");

  a_carrier_flip: assert property (advance && $past(advance) && rise_s2_ff == $past(rise_s2_ff)
    |-> inphase_mixed == -$past(inphase_mixed))
    else $error("cosine arm did not alternate sign");

  a_quad_flip: assert property (advance && $past(advance) && fall_s2_ff == $past(fall_s2_ff)
    |-> quad_mixed == -$past(quad_mixed))
    else $error("sine arm did not alternate sign");

  a_hist_shift: assert property (advance |=> q_hist_ff[9] == $past(q_hist_ff[8]))
    else $error("quadrature history did not shift");

  a_inphase_align: assert property (advance [*5] |=> i_hist_ff[4] == $past(inphase_mixed, 5))
    else $error("in-phase delay is not five steps");

  a_push_valid: assert property (advance |=> iq_valid_o)
    else $error("pushed pair produced no output word");

  a_filter_span: assert property (quad_filtered <= rcd_pkg::FIL_MAX && quad_filtered >= rcd_pkg::FIL_MIN)
    else $error("filtered quadrature out of span");

  a_quant_top: assert property (quad_filtered >= 11'sh11B |-> quad_code == 3'h7)
    else $error("top band not mapped to +7");

  a_quant_lowbnd: assert property (quad_filtered == -11'sh11B |-> quad_code == 3'h0)
    else $error("-283 not mapped to -7");

  a_quant_zero: assert property (quad_filtered == 11'sh000 |-> quad_code == 3'h4)
    else $error("zero not mapped to +1");

  // Every band of the ladder, so a slipped threshold shows at once
  a_quant_p5: assert property (quad_filtered >= 11'sh0BD && quad_filtered <= 11'sh11A
    |-> quad_code == 3'h6)
    else $error("band 189 to 282 not mapped to +5");

  a_quant_p3: assert property (quad_filtered >= 11'sh05F && quad_filtered <= 11'sh0BC
    |-> quad_code == 3'h5)
    else $error("band 95 to 188 not mapped to +3");

  a_quant_p1: assert property (quad_filtered >= 11'sh000 && quad_filtered <= 11'sh05E
    |-> quad_code == 3'h4)
    else $error("band 0 to 94 not mapped to +1");

  a_quant_m1: assert property (quad_filtered >= -11'sh05E && quad_filtered <= -11'sh001
    |-> quad_code == 3'h3)
    else $error("band -94 to -1 not mapped to -1");

  a_quant_m3: assert property (quad_filtered >= -11'sh0BC && quad_filtered <= -11'sh05F
    |-> quad_code == 3'h2)
    else $error("band -188 to -95 not mapped to -3");

  a_quant_m5: assert property (quad_filtered >= -11'sh11A && quad_filtered <= -11'sh0BD
    |-> quad_code == 3'h1)
    else $error("band -282 to -189 not mapped to -5");

  a_quant_m7: assert property (quad_filtered <= -11'sh11B
    |-> quad_code == 3'h0)
    else $error("bottom band not mapped to -7");

  a_inphase_ident: assert property (i_hist_ff[4] == 4'sh7 |-> inphase_code == 3'h7)
    else $error("in-phase +7 level not coded +7");

  // Each centre level lands in its own band, as 47 times the level would
  a_inphase_p5: assert property (inphase_filtered == 4'sh5 |-> inphase_code == 3'h6)
    else $error("in-phase +5 level not coded +5");

  a_inphase_p3: assert property (inphase_filtered == 4'sh3 |-> inphase_code == 3'h5)
    else $error("in-phase +3 level not coded +3");

  a_inphase_p1: assert property (inphase_filtered == 4'sh1 |-> inphase_code == 3'h4)
    else $error("in-phase +1 level not coded +1");

  a_inphase_m1: assert property (inphase_filtered == -4'sh1 |-> inphase_code == 3'h3)
    else $error("in-phase -1 level not coded -1");

  a_inphase_m3: assert property (inphase_filtered == -4'sh3 |-> inphase_code == 3'h2)
    else $error("in-phase -3 level not coded -3");

  a_inphase_m5: assert property (inphase_filtered == -4'sh5 |-> inphase_code == 3'h1)
    else $error("in-phase -5 level not coded -5");

  a_inphase_m7: assert property (inphase_filtered == -4'sh7 |-> inphase_code == 3'h0)
    else $error("in-phase -7 level not coded -7");

  a_buffer_hold: assert property (iq_valid_o && !iq_ready_i |=> iq_valid_o && $stable(inphase_o))
    else $error("buffered word lost during stall");

  // A refused pair is flagged on the next cycle, and nothing else raises the flag
  a_drop_flag: assert property (real_to_complex_mode_i && !buf_ready |=> sample_drop_o)
    else $error("lost input pair not flagged");

  a_drop_quiet: assert property (!real_to_complex_mode_i || buf_ready |=> !sample_drop_o)
    else $error("drop flag raised without a lost pair");

  // Carrier steps once per accepted pair and rests while the pipeline waits
  a_phase_step: assert property (advance |=> phase_ff != $past(phase_ff))
    else $error("carrier phase did not step");

  a_phase_hold: assert property (!advance |=> $stable(phase_ff))
    else $error("carrier phase moved while frozen");

  a_hist_entry: assert property (advance |=> q_hist_ff[0] == $past(quad_mixed))
    else $error("quadrature sample did not enter the history");

  c_stream: cover property (advance [*8]);
  c_stall_fill: cover property (iq_valid_o && !iq_ready_i ##1 !buf_ready);
  c_top_code: cover property (advance && quad_code == 3'h7);
  c_drop: cover property (sample_drop_o);
endmodule

// ===== test/rcd_adc_model.sv
`timescale 1ns/10ps
// Behavioural converter, one 3-bit code per clock half period
module rcd_adc_model (
  input wire logic clk_i,
  input wire logic [1:0] pattern_i,
  output logic [rcd_pkg::CODE_W-1:0] sample_o
);
  logic phase;

  // Tone swaps full scale each pair, default gives random codes
  function automatic logic [rcd_pkg::CODE_W-1:0] pick(input logic ph);
    case (pattern_i)
      2'h1: pick = ph ? 3'h7 : 3'h0;
      2'h2: pick = ph ? 3'h0 : 3'h7;
      default: pick = 3'($urandom % 8);
    endcase
  endfunction

  initial begin
    phase = 1'b0;
    sample_o = 3'h4;
  end

  // Change mid half period so the code is settled at both capture edges
  always @(negedge clk_i) begin
    #6;
    phase = ~phase;
    sample_o = pick(phase);
  end

  // Second code of the pair, taken at the falling edge
  always @(posedge clk_i) begin
    #6;
    sample_o = pick(phase);
  end
endmodule

// ===== test/tb_real_to_complex_downconverter.sv
`timescale 1ns/10ps
module tb_real_to_complex_downconverter;
  logic clk_i, rst_b_i, mode, ready, valid, drop, dexp, mode_q, push, pop;
  logic [1:0] pattern;
  logic [2:0] sample, inph, quad, a_cap;
  logic [5:0] pr;
  logic [6:0] e;
  logic [5:0] pairs[$];
  logic [6:0] exq[$];
  int bad_count, check_count, cnt, sgn, nout, qv;
  int hq[10];
  int ha[5];
  int coef[5] = '{2, -3, 5, -9, 30};

  rcd_downconv uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .real_to_complex_mode_i(mode),
    .antenna_sample_input_i(sample), .iq_valid_o(valid), .iq_ready_i(ready),
    .inphase_o(inph), .quad_o(quad), .sample_drop_o(drop));
  rcd_adc_model adc (.clk_i(clk_i), .pattern_i(pattern), .sample_o(sample));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [2:0] seen, input logic [2:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Code k stands for odd level 2k-7
  function automatic int lvl(input logic [2:0] c);
    return 2 * int'(c) - 7;
  endfunction

  // Fixed ladder shared by both arms
  function automatic logic [2:0] rq(input int v);
    if (v >= 283) return rcd_pkg::CODE_P7;
    if (v >= 189) return rcd_pkg::CODE_P5;
    if (v >= 95) return rcd_pkg::CODE_P3;
    if (v >= 0) return rcd_pkg::CODE_P1;
    if (v >= -94) return rcd_pkg::CODE_M1;
    if (v >= -188) return rcd_pkg::CODE_M3;
    if (v >= -282) return rcd_pkg::CODE_M5;
    return rcd_pkg::CODE_M7;
  endfunction

  // Predictor: buffer occupancy, drop flag and expected words
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt = 0;
      sgn = 1;
      nout = 0;
      dexp = 1'b0;
      exq.delete();
      hq = '{default: 0};
      ha = '{default: 0};
    end else begin
      check(3'(drop), 3'(dexp), "drop flag");
      if (mode && !mode_q) nout = 0;
      pop = cnt > 0 && ready;
      push = mode && cnt < 2 && pairs.size() > 2;
      dexp = mode && cnt == 2;
      if (push) begin
        pr = pairs[2];
        qv = 0;
        for (int p = 0; p < 5; p++) qv += coef[p] * (hq[p] + hq[9-p]) / 2;
        // History fill and stale pairs after resume are not judged
        exq.push_back({nout < 12, rq(47 * ha[4]), rq(qv)});
        for (int k = 9; k > 0; k--) hq[k] = hq[k-1];
        for (int k = 4; k > 0; k--) ha[k] = ha[k-1];
        hq[0] = sgn * lvl(pr[2:0]);
        ha[0] = sgn * lvl(pr[5:3]);
        sgn = -sgn;
        nout++;
      end
      cnt = cnt + push - pop;
    end
    mode_q = mode;
    a_cap = sample;
  end

  // Pair is rising code then falling code
  always @(negedge clk_i) begin
    if (rst_b_i) check(3'(valid), 3'(cnt != 0), "valid");
    pairs.push_front({a_cap, sample});
    if (pairs.size() > 3) void'(pairs.pop_back());
  end

  // Output watcher takes the oldest note per accepted word
  always @(posedge clk_i) begin
    if (rst_b_i && valid === 1'b1 && ready === 1'b1) begin
      if (exq.size() == 0) begin
        check(3'h0, 3'h1, "unexpected word");
      end else begin
        e = exq.pop_front();
        if (!e[6]) begin
          check(inph, e[5:3], "inphase");
          check(quad, e[2:0], "quadrature");
        end
      end
    end
  end

  // Ready mode: 0 stalled, 1 open, 2 random
  task automatic run(input string name, input logic [1:0] pat, input int rdy, input int n);
    @(negedge clk_i);
    pattern <= pat;
    mode <= 1'b1;
    repeat (n) begin
      @(negedge clk_i);
      ready <= (rdy == 2) ? 1'($urandom % 4 != 0) : 1'(rdy);
    end
    $display("test %s done", name);
  endtask

  task automatic do_reset;
    @(negedge clk_i);
    mode <= 1'b0;
    rst_b_i <= 1'b0;
    repeat (8) @(negedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(negedge clk_i);
  endtask

  initial begin
    rst_b_i = 1'b0;
    mode = 1'b0;
    ready = 1'b0;
    pattern = 2'h0;
    bad_count = 0;
    check_count = 0;
    void'($urandom(86944));
    do_reset();
    run("tone up", 2'h1, 1, 60);
    run("tone down", 2'h2, 1, 60);
    run("random ready", 2'h0, 2, 400);
    run("stall", 2'h0, 0, 12);
    run("drain", 2'h0, 1, 30);
    // Mode off mid stream, receiver keeps draining
    @(negedge clk_i);
    mode <= 1'b0;
    repeat (20) @(negedge clk_i);
    run("resume", 2'h0, 1, 60);
    // Asynchronous reset with traffic in flight
    do_reset();
    run("after reset", 2'h0, 2, 200);
    stop_test();
  end

  // Tests take about 900 cycles
  initial begin
    #(4000 * 25);
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end
endmodule
